// ==== cpsf_front.sv ====
// Camera parallel-to-serial front end: pixel capture, enable filter,
// range check, line counting and one serial data and clock lane.
// Assumes camera pins and static pins are asynchronous to REF_CLK_I.
`timescale 1ns/100ps
module cpsf_front (
    input  wire logic                      REF_CLK_I,                  // 50 MHz clock
    input  wire logic                      RSTN_I,                     // Async reset, low
    input  wire logic                      CE_I,                       // Clock enable
    input  wire logic                      PIXEL_CLOCK_I,              // Camera pixel clock
    input  wire logic [cpsf_pkg::PIX_W-1:0] PIXEL_DATA_IN_I,           // Pixel byte
    input  wire logic                      FRAME_SYNC_I,               // Frame sync, high
    input  wire logic                      LINE_SYNC_I,                // Line sync, high
    input  wire logic                      TRANSMIT_ENABLE_I,          // Transmitter on
    input  wire logic                      FREQUENCY_RANGE_SELECT_I,   // Pixel clock band
    input  wire logic                      LINE_COUNT_MODE_I,          // Line counting on
    output logic                           SER_DATA_O,                 // Serial data
    output logic                           SER_DATA_OE_O,              // Data drive enable
    output logic                           SER_CLK_O,                  // Serial clock
    output logic                           SER_CLK_OE_O,               // Clock drive enable
    output logic                           TX_ACTIVE_O,                // Transmitter running
    output logic                           RANGE_OK_O,                 // Period in band
    output logic                           FRAME_END_O,                // Frame end pulse
    output logic [cpsf_pkg::LINE_W-1:0]    LINE_COUNT_O                // Lines in last frame
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    // True when a measured period lies inside the selected band
    function automatic logic in_band(input logic [7:0] per, input logic sel);
        return sel ? ((per >= cpsf_pkg::R1_PER_MIN) && (per <= cpsf_pkg::R1_PER_MAX))
                   : ((per >= cpsf_pkg::R0_PER_MIN) && (per <= cpsf_pkg::R0_PER_MAX));
    endfunction : in_band

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_s1_reg;                                              // Release stage one
    logic rst_n;                                                   // Released reset

    // Assert at once, release after two clean edges
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    localparam int SYNC_W = cpsf_pkg::PIX_W + 6;                   // Camera and static pin inputs
    logic [SYNC_W-1:0] sync1_reg, sync2_reg;                       // Two-stage pipes
    logic [SYNC_W-1:0] sync1_next, sync2_next;                     // Next values
    logic              pclk_d_reg, pclk_d_next;                    // Delayed pixel clock
    logic [7:0]        data_s;                                     // Synced pixel byte
    logic              pclk_s, fsync_s, lsync_s, transmit_enable_s, frequency_range_select_s, mode_s;
    logic              pix_fall;                                   // Pixel clock fell

    assign {mode_s, frequency_range_select_s, transmit_enable_s, lsync_s, fsync_s, pclk_s, data_s} = sync2_reg;
    assign pix_fall = pclk_d_reg & ~pclk_s;

    // Next values for the synchroniser pipes
    always_comb begin
        sync1_next  = {LINE_COUNT_MODE_I, FREQUENCY_RANGE_SELECT_I, TRANSMIT_ENABLE_I,
                       LINE_SYNC_I, FRAME_SYNC_I, PIXEL_CLOCK_I, PIXEL_DATA_IN_I};
        sync2_next  = sync1_reg;
        pclk_d_next = pclk_s;
    end

    // Register the synchronisers
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg  <= '0;
            sync2_reg  <= '0;
            pclk_d_reg <= 1'b0;
        end else if (CE_I) begin
            sync1_reg  <= sync1_next;
            sync2_reg  <= sync2_next;
            pclk_d_reg <= pclk_d_next;
        end
    end

    // ------------------------------------------------------------------
    // Transmit enable filter
    // ------------------------------------------------------------------
    logic       tx_en_reg, tx_en_next;                             // Filtered enable
    logic [9:0] flt_cnt_reg, flt_cnt_next;                         // Steady-level count
    logic [1:0] start_cnt_reg, start_cnt_next;                     // Startup fill count
    logic       started_reg, started_next;                         // Startup done

    // Filter the enable; the first level after start is taken at once
    always_comb begin
        tx_en_next     = tx_en_reg;
        flt_cnt_next   = '0;
        start_cnt_next = start_cnt_reg;
        started_next   = started_reg;
        if (!started_reg) begin
            if (start_cnt_reg == cpsf_pkg::START_FILL_CYC) begin
                started_next = 1'b1;
                tx_en_next   = transmit_enable_s;
            end else begin
                start_cnt_next = start_cnt_reg + 2'h1;
            end
        end else if (transmit_enable_s != tx_en_reg) begin
            // Spikes shorter than the hold time restart the count
            if (flt_cnt_reg == cpsf_pkg::TRANSMIT_ENABLE_HOLD_CYC - 10'h001) begin
                tx_en_next = transmit_enable_s;
            end else begin
                flt_cnt_next = flt_cnt_reg + 10'h001;
            end
        end
    end

    // Register the filter state
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            tx_en_reg     <= 1'b0;
            flt_cnt_reg   <= '0;
            start_cnt_reg <= '0;
            started_reg   <= 1'b0;
        end else if (CE_I) begin
            tx_en_reg     <= tx_en_next;
            flt_cnt_reg   <= flt_cnt_next;
            start_cnt_reg <= start_cnt_next;
            started_reg   <= started_next;
        end
    end

    // ------------------------------------------------------------------
    // Pixel capture, period measure, range and line counting
    // ------------------------------------------------------------------
    logic [7:0]  pix_reg, pix_next;                                // Captured byte
    logic        fs_reg, fs_next, ls_reg, ls_next;                 // Captured syncs
    logic        load_reg, load_next;                              // Byte ready for shifter
    logic [7:0]  per_cnt_reg, per_cnt_next, per_reg, per_next;     // Period in cycles
    logic        range_reg, range_next;                            // In selected band
    logic [10:0] line_cnt_reg, line_cnt_next;                      // Lines in frame
    logic [10:0] line_out_reg, line_out_next;                      // Count of last frame
    logic        fend_reg, fend_next;                              // Frame end pulse
    logic        fs_fell, ls_fell;                                 // Sync falls this pixel

    assign fs_fell = fs_reg & ~fsync_s;
    assign ls_fell = ls_reg & ~lsync_s;

    // Sample byte, syncs and period on the pixel clock fall only; range flag every cycle
    always_comb begin
        pix_next      = pix_reg;
        fs_next       = fs_reg;
        ls_next       = ls_reg;
        load_next     = pix_fall;
        per_cnt_next  = (per_cnt_reg == 8'hFF) ? per_cnt_reg : per_cnt_reg + 8'h01;
        per_next      = per_reg;
        range_next    = in_band(per_reg, frequency_range_select_s);
        line_cnt_next = line_cnt_reg;
        line_out_next = line_out_reg;
        fend_next     = 1'b0;
        if (pix_fall) begin
            pix_next     = data_s;
            fs_next      = fsync_s;
            ls_next      = lsync_s;
            per_next     = (per_cnt_reg == 8'hFF) ? per_cnt_reg : per_cnt_reg + 8'h01;
            per_cnt_next = '0;
            if (fsync_s && !fs_reg) begin
                line_cnt_next = '0;                                // New frame
            end else if (ls_fell && (line_cnt_reg != 11'h7FF)) begin
                line_cnt_next = line_cnt_reg + 11'h001;
            end
            // Counting lets frame end stand apart from the last line end
            if (fs_fell && (mode_s || ls_fell)) begin
                fend_next     = 1'b1;
                line_out_next = line_cnt_next;                     // Saturating count
            end
        end
    end

    // Register the capture state
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            pix_reg      <= '0;
            fs_reg       <= 1'b0;
            ls_reg       <= 1'b0;
            load_reg     <= 1'b0;
            per_cnt_reg  <= cpsf_pkg::PER_RST;
            per_reg      <= cpsf_pkg::PER_RST;
            range_reg    <= 1'b0;
            line_cnt_reg <= '0;
            line_out_reg <= '0;
            fend_reg     <= 1'b0;
        end else if (CE_I) begin
            pix_reg      <= pix_next;
            fs_reg       <= fs_next;
            ls_reg       <= ls_next;
            load_reg     <= load_next;
            per_cnt_reg  <= per_cnt_next;
            per_reg      <= per_next;
            range_reg    <= range_next;
            line_cnt_reg <= line_cnt_next;
            line_out_reg <= line_out_next;
            fend_reg     <= fend_next;
        end
    end

    // ------------------------------------------------------------------
    // Serial lane
    // ------------------------------------------------------------------
    logic [7:0] shift_reg, shift_next;                             // Bits to send
    logic [3:0] left_reg, left_next;                               // Bits still to send
    logic [7:0] half_reg, half_next;                               // Half-bit counter
    logic       sclk_reg, sclk_next;                               // Serial clock
    logic       sdat_reg, sdat_next;                               // Serial data
    logic [7:0] half_lim;                                          // Half-bit length

    // A sixteenth of the pixel period, never below one cycle
    assign half_lim = ((per_reg >> cpsf_pkg::HALF_SHIFT) == 8'h00) ? 8'h01
                    : (per_reg >> cpsf_pkg::HALF_SHIFT);

    // Shift MSB first; while enabled, data moves only when the serial clock falls
    always_comb begin
        shift_next = shift_reg;
        left_next  = left_reg;
        half_next  = half_reg;
        sclk_next  = sclk_reg;
        sdat_next  = sdat_reg;
        if (!tx_en_reg) begin
            // Shutdown: clock stopped low, lane idle
            shift_next = '0;
            left_next  = '0;
            half_next  = cpsf_pkg::HALF_RST;
            sclk_next  = 1'b0;
            sdat_next  = 1'b0;
        end else begin
            if (half_reg >= half_lim) begin
                half_next = cpsf_pkg::HALF_RST;
                sclk_next = ~sclk_reg;
                if (sclk_reg) begin
                    // Falling serial clock: present next bit for the rise
                    sdat_next  = (left_reg != 4'h0) ? shift_reg[7] : 1'b0;
                    shift_next = {shift_reg[6:0], 1'b0};
                    left_next  = (left_reg != 4'h0) ? left_reg - 4'h1 : 4'h0;
                end
            end else begin
                half_next = half_reg + 8'h01;
            end
            // A new byte replaces whatever remains of the old one
            if (load_reg) begin
                shift_next = pix_reg;
                left_next  = cpsf_pkg::BITS_PER_PIX;
            end
        end
    end

    // Register the serial lane
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= '0;
            left_reg  <= '0;
            half_reg  <= cpsf_pkg::HALF_RST;
            sclk_reg  <= 1'b0;
            sdat_reg  <= 1'b0;
        end else if (CE_I) begin
            shift_reg <= shift_next;
            left_reg  <= left_next;
            half_reg  <= half_next;
            sclk_reg  <= sclk_next;
            sdat_reg  <= sdat_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign SER_DATA_O    = sdat_reg;
    assign SER_DATA_OE_O = tx_en_reg;
    assign SER_CLK_O     = sclk_reg;
    assign SER_CLK_OE_O  = tx_en_reg;
    assign TX_ACTIVE_O   = tx_en_reg;
    assign RANGE_OK_O    = range_reg;
    assign FRAME_END_O   = fend_reg;
    assign LINE_COUNT_O  = line_out_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_pixel_capture: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        (CE_I && pix_fall) |=> (pix_reg == $past(data_s)))
        else $error("pixel byte not taken on pixel clock fall");
    a_frame_sync_sample: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        (CE_I && pix_fall) |=> (fs_reg == $past(fsync_s)))
        else $error("frame sync not sampled on pixel clock fall");
    a_line_sync_sample: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        (CE_I && !pix_fall) |=> $stable(ls_reg))
        else $error("line sync changed away from pixel clock fall");
    a_data_on_fall: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        (tx_en_reg && $past(tx_en_reg) && $changed(sdat_reg)) |-> $fell(sclk_reg))
        else $error("serial data moved outside a serial clock fall");
    a_drive_off: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        (!TX_ACTIVE_O && $past(!TX_ACTIVE_O && CE_I))
            |-> (!SER_DATA_OE_O && !SER_CLK_OE_O && !SER_DATA_O))
        else $error("serial lane driven while transmitter off");
    a_shutdown_idle: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        (CE_I && !tx_en_reg) |=> (!sclk_reg && !sdat_reg && (left_reg == 4'h0)))
        else $error("serial clock still running in shutdown");
    a_filter_hold: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        ($changed(tx_en_reg) && $past(started_reg))
            |-> ($past(flt_cnt_reg) == cpsf_pkg::TRANSMIT_ENABLE_HOLD_CYC - 10'h001))
        else $error("enable changed before hold time expired");
    a_powerup_direct: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        $rose(started_reg) |-> (tx_en_reg == $past(transmit_enable_s)))
        else $error("start-up enable not taken from pin at once");
    a_range_check: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        $past(CE_I) |-> (range_reg == in_band($past(per_reg), $past(frequency_range_select_s))))
        else $error("range flag does not match selected band");
    a_frame_end_mode: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        (CE_I && pix_fall && fs_fell && !mode_s && !ls_fell) |=> !fend_reg)
        else $error("frame end flagged without counting and without line end");
    a_eight_bits: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
        (CE_I && tx_en_reg && load_reg) |=> (left_reg == cpsf_pkg::BITS_PER_PIX))
        else $error("serializer not loaded with eight bits");

endmodule : cpsf_front

// ==== cpsf_pkg.sv ====
// Shared constants for the camera parallel-to-serial front end.
// Assumes a 50 MHz reference clock; the hold and range counts are derived from its period.
package cpsf_pkg;

    // ------------------------------------------------------------------
    // Clock and widths
    // ------------------------------------------------------------------
    localparam int         REF_PERIOD_PS = 20000;          // Reference clock period
    localparam int         PIX_W         = 8;              // Pixel bus width
    localparam int         PER_W         = 8;              // Pixel period counter width
    localparam int         LINE_W        = 11;             // Line counter width
    localparam int         BIT_CNT_W     = 4;              // Bits-left counter width
    localparam logic [3:0] BITS_PER_PIX  = 4'h8;           // Serial bits per pixel
    localparam int         HALF_SHIFT    = 4;              // Half bit = period / 16

    // ------------------------------------------------------------------
    // Transmit enable glitch filter
    // ------------------------------------------------------------------
    localparam int TRANSMIT_ENABLE_HOLD_NS = 10000;                   // Hold time, 10 us
    // More than the hold time: floor of the count plus one cycle
    localparam int TRANSMIT_ENABLE_HOLD_INT = (TRANSMIT_ENABLE_HOLD_NS * 1000) / REF_PERIOD_PS + 1;
    localparam logic [9:0] TRANSMIT_ENABLE_HOLD_CYC = 10'(TRANSMIT_ENABLE_HOLD_INT);
    localparam logic [1:0] START_FILL_CYC = 2'h2;          // Synchroniser fill time

    // ------------------------------------------------------------------
    // Pixel clock ranges, in kHz, and their periods in reference cycles
    // ------------------------------------------------------------------
    localparam longint PS_PER_KHZ  = 1000000000;           // Picoseconds in 1/kHz
    localparam longint R0_MIN_KHZ  = 3500;                 // Range 0 slowest
    localparam longint R0_MAX_KHZ  = 13000;                // Range 0 fastest
    localparam longint R1_MIN_KHZ  = 7000;                 // Range 1 slowest
    localparam longint R1_MAX_KHZ  = 27000;                // Range 1 fastest
    // Longest period rounds down, shortest rounds up
    localparam logic [7:0] R0_PER_MAX = 8'(PS_PER_KHZ / (R0_MIN_KHZ * REF_PERIOD_PS));
    localparam logic [7:0] R0_PER_MIN =
        8'((PS_PER_KHZ + R0_MAX_KHZ * REF_PERIOD_PS - 1) / (R0_MAX_KHZ * REF_PERIOD_PS));
    localparam logic [7:0] R1_PER_MAX = 8'(PS_PER_KHZ / (R1_MIN_KHZ * REF_PERIOD_PS));
    localparam logic [7:0] R1_PER_MIN =
        8'((PS_PER_KHZ + R1_MAX_KHZ * REF_PERIOD_PS - 1) / (R1_MAX_KHZ * REF_PERIOD_PS));

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PER_RST  = 8'h00;               // Measured period
    localparam logic [7:0] HALF_RST = 8'h01;               // Half-bit counter

endpackage : cpsf_pkg

// ==== cpsf_rx_model.sv ====
// Serial receiver model at the far end of the serial lane.
// Assumes the lane is sampled on the rising edge of the serial clock.
`timescale 1ns/100ps
module cpsf_rx_model (
    input  wire logic        ser_clk_i,      // Serial clock
    input  wire logic        ser_clk_oe_i,   // Clock lane driven
    input  wire logic        ser_data_i,     // Serial data
    input  wire logic        ser_data_oe_i,  // Data lane driven
    output logic [63:0]      hist_o          // Recent bits, newest at bit 0
);
    // -------------------------------------------------------------
    // Sampling
    // -------------------------------------------------------------
    logic [63:0] hist_reg = 64'h0;  // Shift history, one writer
    assign hist_o = hist_reg;
    // Take a bit on each rise while both lanes are driven
    always @(posedge ser_clk_i) begin
        if (ser_clk_oe_i === 1'b1 && ser_data_oe_i === 1'b1) begin
            hist_reg <= {hist_reg[62:0], ser_data_i};
        end
    end
endmodule : cpsf_rx_model

// ==== camera_parallel_serial_front_test.sv ====
// Self-checking bench for the camera parallel-to-serial front end.
// Assumes cpsf_front and cpsf_rx_model are compiled first.
`timescale 1ns/100ps
module camera_parallel_serial_front_test;
    logic        clk = 1'b0, rstn = 1'b0, pclk = 1'b1, fs = 1'b0, ls = 1'b0;
    logic        transmit_enable = 1'b1, frequency_range_select = 1'b0, ce = 1'b1;
    logic        mode = 1'b1;
    logic [7:0]  pd = 8'h00;                             // Pixel byte
    logic        sdat, sdoe, sclk, scoe, txa, rok, fe;  // Design outputs
    logic [10:0] lc;                                     // Line count
    logic [63:0] hist;                                   // Received bits
    logic [7:0]  prev, d;                                // Byte history
    int          num_errors = 0, checks = 0, fe_cnt = 0, k, n, f0;
    always #10 clk = ~clk;                               // 50 MHz
    // Count frame-end pulses
    always @(negedge clk) if (fe === 1'b1) fe_cnt++;
    cpsf_front dut (.REF_CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .PIXEL_CLOCK_I(pclk),
        .PIXEL_DATA_IN_I(pd), .FRAME_SYNC_I(fs), .LINE_SYNC_I(ls),
        .TRANSMIT_ENABLE_I(transmit_enable), .FREQUENCY_RANGE_SELECT_I(frequency_range_select),
        .LINE_COUNT_MODE_I(mode), .SER_DATA_O(sdat), .SER_DATA_OE_O(sdoe),
        .SER_CLK_O(sclk), .SER_CLK_OE_O(scoe), .TX_ACTIVE_O(txa),
        .RANGE_OK_O(rok), .FRAME_END_O(fe), .LINE_COUNT_O(lc));
    cpsf_rx_model rx (.ser_clk_i(sclk), .ser_clk_oe_i(scoe), .ser_data_i(sdat),
        .ser_data_oe_i(sdoe), .hist_o(hist));
    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d, errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, s);
        end
    endtask : chk
    // One pixel period: syncs and data set with the rise, captured at the fall
    task automatic pix(input int per, input logic [7:0] dd, input logic f, input logic l);
        @(negedge clk);
        pd = dd; fs = f; ls = l; pclk = 1'b1;
        repeat (per / 2) @(negedge clk);
        pclk = 1'b0;
        repeat (per - per / 2 - 1) @(negedge clk);
    endtask : pix
    // Bounded wait for the transmitter level; a timeout closes the run
    task automatic wait_tx(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (txa !== lvl) begin
            @(negedge clk);
            cnt++;
            if (cnt == lim) begin
                chk("tx wait", 16'(lvl), 16'(txa));
                final_report();
            end
        end
    endtask : wait_tx
    // Band check worked out from the supported pixel clock ranges
    function automatic logic in_band(input logic s, input int per);
        int khz = 50000 / per;
        return s ? (khz >= 7000 && khz <= 27000) : (khz >= 3500 && khz <= 13000);
    endfunction : in_band
    function automatic logic found(input logic [63:0] h, input logic [7:0] b);
        for (int j = 0; j < 16; j++) if (h[j+:8] === b) return 1'b1;
        return 1'b0;
    endfunction : found
    // Frame with n lines; 'tog' lets frame and line sync fall together
    task automatic frame(input logic m, input int nl, input logic tog);
        mode = m; f0 = fe_cnt;
        pix(8, 8'h00, 1'b1, 1'b0);
        for (int i = 0; i < nl; i++) begin
            pix(8, 8'($urandom), 1'b1, 1'b1);
            if (!(tog && i == nl - 1)) pix(8, 8'h00, 1'b1, 1'b0);
        end
        repeat (2) pix(8, 8'h00, 1'b0, 1'b0);
        chk("frame end", 16'(m | tog), 16'(fe_cnt - f0));
        if (m | tog) chk("line count", 16'(nl), 16'(lc));
    endtask : frame
    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        void'($urandom(31978));
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        wait_tx(1'b1, 20, k);
        chk("startup enable", 16'h1, 16'(k <= 10));
        chk("lanes driven", 16'h3, {14'h0, sdoe, scoe});
        $display("test startup done");
        prev = 8'h00;
        for (int i = 0; i < 10; i++) begin
            d = {1'b1, 7'($urandom)};
            pix(40, d, 1'b0, 1'b0);
            if (i > 2) chk("serial byte", {8'h0, prev}, found(hist, prev) ? prev : ~prev);
            prev = d;
        end
        $display("test serial done");
        for (int s = 0; s < 2; s++) begin
            for (int p = 0; p < 3; p++) begin
                n = (p == 0) ? 6 : (p == 1) ? 8 : 40;
                frequency_range_select = s[0];
                repeat (3) pix(n, 8'h00, 1'b0, 1'b0);
                chk("range ok", 16'(in_band(s[0], n)), 16'(rok));
            end
        end
        $display("test range done");
        frame(1'b1, 1 + $urandom % 6, 1'b0);
        frame(1'b0, 1 + $urandom % 6, 1'b1);
        frame(1'b0, 1 + $urandom % 6, 1'b0);
        $display("test frame done");
        ce = 1'b0;
        transmit_enable = 1'b0;
        repeat (600) @(negedge clk);
        transmit_enable = 1'b1;
        ce = 1'b1;
        chk("frozen enable", 16'h1, 16'(txa));
        repeat (10) @(negedge clk);
        transmit_enable = 1'b0;
        repeat (400) @(negedge clk);
        transmit_enable = 1'b1;
        repeat (600) @(negedge clk);
        chk("glitch ignored", 16'h1, 16'(txa));
        transmit_enable = 1'b0;
        wait_tx(1'b0, 600, k);
        chk("off delay", 16'h1, 16'(k > 500 && k <= 506));
        repeat (3) pix(40, 8'hFF, 1'b0, 1'b0);
        chk("lanes off", 16'h0, {12'h0, sdoe, scoe, sclk, sdat});
        transmit_enable = 1'b1;
        wait_tx(1'b1, 600, k);
        chk("on delay", 16'h1, 16'(k > 500 && k <= 506));
        $display("test enable done");
        final_report();
    end
endmodule : camera_parallel_serial_front_test
